/* File: src/drpm_pkg.sv */
package drpm_pkg;
   // Link clock is the system clock divided by two.
   localparam int CLK_NS = 8;
   localparam int TCK_NS = 2 * CLK_NS;
   // Analog times in ns, converted to whole link cycles rounded up.
   localparam int T_RCD_NS = 18;
   localparam int T_RAS_NS = 42;
   localparam int T_RPPB_NS = 18;
   localparam int T_RPAB_NS = 21;
   localparam int T_RC_NS = 63;
   localparam int T_RTP_NS = 8;
   localparam int T_WR_NS = 18;
   localparam int N_RTP_MIN = 8;
   localparam int BL = 16;
   localparam int WL = 6;
   localparam int RL = 14;
   localparam int PREFETCH = 16;
   localparam int CW = 6;

   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + TCK_NS - 1) / TCK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int imax(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   localparam logic [CW-1:0] N_RCD = CW'(cyc_up(T_RCD_NS));
   localparam logic [CW-1:0] N_RAS = CW'(cyc_up(T_RAS_NS));
   localparam logic [CW-1:0] N_RPPB = CW'(cyc_up(T_RPPB_NS));
   localparam logic [CW-1:0] N_RPAB = CW'(cyc_up(T_RPAB_NS));
   localparam logic [CW-1:0] N_RC = CW'(cyc_up(T_RC_NS));
   localparam int N_RTP = imax(N_RTP_MIN, cyc_up(T_RTP_NS));
   localparam logic [CW-1:0] N_RD2PRE = CW'(imax(BL / 2, BL / 2 - 8 + N_RTP));
   localparam logic [CW-1:0] N_WR2PRE = CW'(WL + BL / 2 + 1 + cyc_up(T_WR_NS));

   // Data phase offsets in system clocks, one data beat per system clock.
   localparam logic [6:0] W_START = 7'(2 * WL);
   localparam logic [6:0] W_END = 7'(2 * WL + BL);
   localparam logic [6:0] RD_CAP = 7'(2 * RL + 2);
   localparam logic [6:0] R_END = 7'(2 * RL + 2 + BL);

   // First command word opcodes on CA[4:0]; CA[5] carries the AP or AB flag.
   localparam logic [4:0] OP_ACT = 5'h01;
   localparam logic [4:0] OP_RD = 5'h02;
   localparam logic [4:0] OP_WR = 5'h04;
   localparam logic [4:0] OP_MWR = 5'h06;
   localparam logic [4:0] OP_PRE = 5'h10;

   typedef enum logic [2:0] {
      DRPM_CMD_ACT = 3'h0,
      DRPM_CMD_RD = 3'h1,
      DRPM_CMD_WR = 3'h2,
      DRPM_CMD_MWR = 3'h3,
      DRPM_CMD_PRE = 3'h4
   } drpm_cmd_t;

   typedef enum logic [1:0] {
      DRPM_ST_IDLE = 2'b00,
      DRPM_ST_CA1 = 2'b01,
      DRPM_ST_CA2 = 2'b11,
      DRPM_ST_DATA = 2'b10
   } drpm_state_t;

   typedef struct packed {
      drpm_cmd_t cmd;
      logic [2:0] bank;
      logic flag;
      logic [16*BL-1:0] wdata;
      logic [2*BL-1:0] wmask;
   } drpm_req_t;

   typedef struct packed {
      logic open;
      logic [CW-1:0] rcd;
      logic [CW-1:0] pre;
      logic [CW-1:0] act;
      logic [CW-1:0] rc;
   } drpm_bank_t;

   typedef struct packed {
      drpm_state_t st;
      logic phase;
      logic cs;
      logic [5:0] ca;
      drpm_bank_t [7:0] bank;
      drpm_req_t cur;
      logic [6:0] dcnt;
      logic [15:0] dq_o;
      logic dq_oe;
      logic [1:0] dmi_o;
      logic dmi_oe;
      logic [17:0] s1;
      logic [17:0] s2;
      logic [16*BL-1:0] rdata;
      logic rd_valid;
      logic err;
   } drpm_st_t;
endpackage

/* File: src/drpm_ctrl.sv */
// How it works
// - Plain write keeps DMI low unless write DBI inverts a byte, no masking.
// - Any masked data goes out as Masked Write.
// - No Masked Write while mask disabled.
// - All-bank precharge waits tRPab before activate, the same 2 link cycles as per-bank tRPpb.
// - Precharge after read waits BL/2, tRAS.
// - Read-to-precharge counts from BL/2 minus 8.
// - Write-to-precharge waits WL+BL/2+1+tWR.
// - Activate only after row precharge time.
// - Auto precharge column only after tRCD.
// - Activate after auto precharge needs tRP, tRC.
`timescale 1ns/100ps
`default_nettype none
module drpm_ctrl (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cfg_dm_en,
   input wire logic cfg_wdbi_en,
   input wire logic cfg_rdbi_en,
   input wire logic req_valid,
   output logic req_ready,
   input wire drpm_pkg::drpm_req_t req,
   output logic req_err,
   output logic rd_valid,
   output logic [255:0] rd_data,
   output logic ck_out,
   output logic cs_out,
   output logic [5:0] ca_out,
   output logic [15:0] dq_o,
   output logic dq_oe,
   input wire logic [15:0] dq_i,
   output logic [1:0] dmi_o,
   output logic dmi_oe,
   input wire logic [1:0] dmi_i
);
   drpm_pkg::drpm_st_t st_reg;
   drpm_pkg::drpm_st_t st_next;
   logic tick;
   logic need_mask;
   logic bad_req;
   logic legal;
   logic all_pre_ok;
   drpm_pkg::drpm_cmd_t eff_cmd;
   drpm_pkg::drpm_bank_t rb;

   function automatic logic [3:0] ones(input logic [7:0] d);
      logic [3:0] n;
      n = 4'h0;
      for (int k = 0; k < 8; k++) begin
         n = n + {3'h0, d[k]};
      end
      return n;
   endfunction

   function automatic logic [8:0] enc(input logic [7:0] d, input logic m, input logic mwr,
                                     input logic wdbi);
      logic [8:0] r;
      r = {1'b0, d};
      if (mwr && m && wdbi) begin
         r = {1'b0, 8'hff};
      end else if (mwr && m) begin
         r = {1'b1, d};
      end else if (wdbi && ones(d) > 4'h4) begin
         r = {1'b1, ~d};
      end
      return r;
   endfunction

   localparam int CW_F = drpm_pkg::CW;

   function automatic logic [CW_F-1:0] dec(input logic [CW_F-1:0] v);
      return (v != '0) ? v - CW_F'(1) : v;
   endfunction

   function automatic logic [CW_F-1:0] mx(input logic [CW_F-1:0] a, input logic [CW_F-1:0] b);
      return (a > b) ? a : b;
   endfunction

   assign tick = st_reg.phase;
   assign rb = st_reg.bank[req.bank];
   assign need_mask = (req.cmd == drpm_pkg::DRPM_CMD_WR) && (req.wmask != '0);
   assign eff_cmd = need_mask ? drpm_pkg::DRPM_CMD_MWR : req.cmd;
   assign bad_req = (eff_cmd == drpm_pkg::DRPM_CMD_MWR) && !cfg_dm_en;

   always_comb begin
      all_pre_ok = 1'b1;
      for (int b = 0; b < 8; b++) begin
         if (st_reg.bank[b].pre != '0) begin
            all_pre_ok = 1'b0;
         end
      end
   end

   always_comb begin
      legal = 1'b0;
      unique case (eff_cmd)
         drpm_pkg::DRPM_CMD_ACT: legal = !rb.open && rb.act == '0 && rb.rc == '0;
         drpm_pkg::DRPM_CMD_RD, drpm_pkg::DRPM_CMD_WR, drpm_pkg::DRPM_CMD_MWR: legal = rb.open && rb.rcd == '0;
         drpm_pkg::DRPM_CMD_PRE: legal = req.flag ? all_pre_ok : (rb.pre == '0);
         default: legal = 1'b0;
      endcase
   end

   assign req_ready = (st_reg.st == drpm_pkg::DRPM_ST_IDLE) && tick && (bad_req || legal);

   always_comb begin
      logic [3:0] bi;
      logic [3:0] ri;
      logic [8:0] e;
      logic [2:0] b0;
      logic wr;
      bi = 4'h0;
      ri = 4'h0;
      e = 9'h0;
      b0 = st_reg.cur.bank;
      wr = st_reg.cur.cmd == drpm_pkg::DRPM_CMD_WR || st_reg.cur.cmd == drpm_pkg::DRPM_CMD_MWR;
      st_next = st_reg;
      st_next.phase = ~st_reg.phase;
      st_next.s1 = {dmi_i, dq_i};
      st_next.s2 = st_reg.s1;
      st_next.rd_valid = 1'b0;
      st_next.err = 1'b0;
      st_next.dq_oe = 1'b0;
      st_next.dmi_oe = 1'b0;
      st_next.dmi_o = 2'h0;
      if (tick) begin
         for (int b = 0; b < 8; b++) begin
            st_next.bank[b].rcd = dec(st_reg.bank[b].rcd);
            st_next.bank[b].pre = dec(st_reg.bank[b].pre);
            st_next.bank[b].act = dec(st_reg.bank[b].act);
            st_next.bank[b].rc = dec(st_reg.bank[b].rc);
         end
      end
      unique case (st_reg.st)
         drpm_pkg::DRPM_ST_IDLE: begin
            if (req_valid && req_ready) begin
               if (bad_req) begin
                  st_next.err = 1'b1;
               end else begin
                  st_next.cur = req;
                  st_next.cur.cmd = eff_cmd;
                  st_next.st = drpm_pkg::DRPM_ST_CA1;
                  st_next.cs = 1'b1;
                  st_next.ca[5] = req.flag;
                  unique case (eff_cmd)
                     drpm_pkg::DRPM_CMD_ACT: st_next.ca[4:0] = drpm_pkg::OP_ACT;
                     drpm_pkg::DRPM_CMD_RD: st_next.ca[4:0] = drpm_pkg::OP_RD;
                     drpm_pkg::DRPM_CMD_WR: st_next.ca[4:0] = drpm_pkg::OP_WR;
                     drpm_pkg::DRPM_CMD_MWR: st_next.ca[4:0] = drpm_pkg::OP_MWR;
                     default: st_next.ca[4:0] = drpm_pkg::OP_PRE;
                  endcase
               end
            end
         end
         drpm_pkg::DRPM_ST_CA1: begin
            if (tick) begin
               st_next.st = drpm_pkg::DRPM_ST_CA2;
               st_next.cs = 1'b0;
               st_next.ca = {3'h0, st_reg.cur.bank};
            end
         end
         drpm_pkg::DRPM_ST_CA2: begin
            if (tick) begin
               st_next.ca = 6'h00;
               st_next.dcnt = 7'h00;
               st_next.st = drpm_pkg::DRPM_ST_DATA;
               unique case (st_reg.cur.cmd)
                  drpm_pkg::DRPM_CMD_ACT: begin
                     st_next.st = drpm_pkg::DRPM_ST_IDLE;
                     st_next.bank[b0].open = 1'b1;
                     st_next.bank[b0].rcd = drpm_pkg::N_RCD;
                     st_next.bank[b0].pre = drpm_pkg::N_RAS;
                     st_next.bank[b0].rc = drpm_pkg::N_RC;
                  end
                  drpm_pkg::DRPM_CMD_RD: begin
                     if (st_reg.cur.flag) begin
                        st_next.bank[b0].act = CW_F'(mx(st_next.bank[b0].pre, drpm_pkg::N_RD2PRE)
                                                    + drpm_pkg::N_RPPB);
                        st_next.bank[b0].open = 1'b0;
                        st_next.bank[b0].pre = '0;
                     end else begin
                        st_next.bank[b0].pre = mx(st_next.bank[b0].pre, drpm_pkg::N_RD2PRE);
                     end
                  end
                  drpm_pkg::DRPM_CMD_PRE: begin
                     st_next.st = drpm_pkg::DRPM_ST_IDLE;
                     if (st_reg.cur.flag) begin
                        for (int b = 0; b < 8; b++) begin
                           st_next.bank[b].act = mx(st_next.bank[b].act, drpm_pkg::N_RPAB);
                           st_next.bank[b].open = 1'b0;
                        end
                     end else if (st_reg.bank[b0].open) begin
                        st_next.bank[b0].act = mx(st_next.bank[b0].act, drpm_pkg::N_RPPB);
                        st_next.bank[b0].open = 1'b0;
                     end
                  end
                  default: begin
                     if (st_reg.cur.flag) begin
                        st_next.bank[b0].act = CW_F'(mx(st_next.bank[b0].pre, drpm_pkg::N_WR2PRE)
                                                    + drpm_pkg::N_RPPB);
                        st_next.bank[b0].open = 1'b0;
                        st_next.bank[b0].pre = '0;
                     end else begin
                        st_next.bank[b0].pre = mx(st_next.bank[b0].pre, drpm_pkg::N_WR2PRE);
                     end
                  end
               endcase
            end
         end
         drpm_pkg::DRPM_ST_DATA: begin
            st_next.dcnt = st_reg.dcnt + 7'h01;
            if (wr) begin
               if (st_reg.dcnt >= drpm_pkg::W_START && st_reg.dcnt < drpm_pkg::W_END) begin
                  bi = 4'(st_reg.dcnt - drpm_pkg::W_START);
                  st_next.dq_oe = 1'b1;
                  st_next.dmi_oe = 1'b1;
                  for (int y = 0; y < 2; y++) begin
                     e = enc(st_reg.cur.wdata[{bi, 4'h0} + 8'(y * 8) +: 8], st_reg.cur.wmask[{bi, 1'b0} + 5'(y)],
                             st_reg.cur.cmd == drpm_pkg::DRPM_CMD_MWR, cfg_wdbi_en);
                     st_next.dq_o[y*8 +: 8] = e[7:0];
                     st_next.dmi_o[y] = e[8];
                  end
               end
               if (st_reg.dcnt == drpm_pkg::W_END) begin
                  st_next.st = drpm_pkg::DRPM_ST_IDLE;
               end
            end else begin
               if (st_reg.dcnt >= drpm_pkg::RD_CAP && st_reg.dcnt < drpm_pkg::R_END) begin
                  ri = 4'(st_reg.dcnt - drpm_pkg::RD_CAP);
                  for (int y = 0; y < 2; y++) begin
                     st_next.rdata[{ri, 4'h0} + 8'(y * 8) +: 8] = (cfg_rdbi_en && st_reg.s2[16 + y]) ?
                        ~st_reg.s2[y*8 +: 8] : st_reg.s2[y*8 +: 8];
                  end
               end
               if (st_reg.dcnt == drpm_pkg::R_END) begin
                  st_next.st = drpm_pkg::DRPM_ST_IDLE;
                  st_next.rd_valid = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ck_out = st_reg.phase;
   assign cs_out = st_reg.cs;
   assign ca_out = st_reg.ca;
   assign dq_o = st_reg.dq_o;
   assign dq_oe = st_reg.dq_oe;
   assign dmi_o = st_reg.dmi_o;
   assign dmi_oe = st_reg.dmi_oe;
   assign rd_valid = st_reg.rd_valid;
   assign rd_data = st_reg.rdata;
   assign req_err = st_reg.err;

   a_plain_wr_dmi: assert property (@(posedge clock) disable iff (!rst_n)
      st_reg.dmi_oe && st_reg.cur.cmd == drpm_pkg::DRPM_CMD_WR && !cfg_wdbi_en |-> st_reg.dmi_o == 2'h0)
      else $error("plain write drove DMI high");
   a_mask_uses_mwr: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(st_reg.cs) && st_reg.ca[4:0] == drpm_pkg::OP_WR |-> st_reg.cur.wmask == '0)
      else $error("masked data sent as plain write");
   a_no_mwr_off: assert property (@(posedge clock) disable iff (!rst_n)
      req_valid && req_ready && eff_cmd == drpm_pkg::DRPM_CMD_MWR && !cfg_dm_en |=> req_err && !st_reg.cs)
      else $error("masked write issued with mask off");
   a_bank_word: assert property (@(posedge clock) disable iff (!rst_n)
      st_reg.st == drpm_pkg::DRPM_ST_CA1 && tick |=> st_reg.ca == {3'h0, st_reg.cur.bank} && !st_reg.cs)
      else $error("second word lacks bank address");
   a_preall_wait: assert property (@(posedge clock) disable iff (!rst_n)
      st_reg.st == drpm_pkg::DRPM_ST_CA2 && tick && st_reg.cur.cmd == drpm_pkg::DRPM_CMD_PRE && st_reg.cur.flag
      |=> !(req_ready && eff_cmd == drpm_pkg::DRPM_CMD_ACT) [*3])
      else $error("activate too soon after all-bank precharge");
   a_rd_pre_gap: assert property (@(posedge clock) disable iff (!rst_n)
      st_reg.st == drpm_pkg::DRPM_ST_CA2 && tick && st_reg.cur.cmd == drpm_pkg::DRPM_CMD_RD && !st_reg.cur.flag
      |=> st_reg.bank[$past(st_reg.cur.bank)].pre >= drpm_pkg::N_RD2PRE)
      else $error("read to precharge spacing lost");
   a_wr_pre_gap: assert property (@(posedge clock) disable iff (!rst_n)
      st_reg.st == drpm_pkg::DRPM_ST_CA2 && tick && st_reg.cur.cmd == drpm_pkg::DRPM_CMD_WR && !st_reg.cur.flag
      |=> st_reg.bank[$past(st_reg.cur.bank)].pre >= drpm_pkg::N_WR2PRE)
      else $error("write recovery spacing lost");
   a_act_after_rp: assert property (@(posedge clock) disable iff (!rst_n)
      req_valid && req_ready && eff_cmd == drpm_pkg::DRPM_CMD_ACT && !bad_req |-> rb.act == '0 && rb.rc == '0)
      else $error("activate before precharge time");
   a_col_after_rcd: assert property (@(posedge clock) disable iff (!rst_n)
      req_valid && req_ready && eff_cmd == drpm_pkg::DRPM_CMD_RD |-> rb.open && rb.rcd == '0)
      else $error("column command before tRCD");
   c_act: cover property (@(posedge clock) disable iff (!rst_n) $rose(st_reg.cs) && st_reg.ca[4:0] == drpm_pkg::OP_ACT);
   c_rd_done: cover property (@(posedge clock) disable iff (!rst_n) st_reg.rd_valid);
   c_mwr: cover property (@(posedge clock) disable iff (!rst_n) $rose(st_reg.cs) && st_reg.ca[4:0] == drpm_pkg::OP_MWR);
   c_preall: cover property (@(posedge clock) disable iff (!rst_n) $rose(st_reg.cs) && st_reg.ca == {1'b1, drpm_pkg::OP_PRE});
endmodule
`default_nettype wire

/* File: verification/drpm_dev_model.sv */
`timescale 1ns/100ps
`default_nettype none
module drpm_dev_model (
   input wire logic ck_out,
   input wire logic cs_out,
   input wire logic [5:0] ca_out,
   input wire logic [15:0] dq_o,
   input wire logic dq_oe,
   input wire logic [1:0] dmi_o,
   input wire logic dmi_oe,
   input wire logic dm_en,
   input wire logic wdbi_en,
   input wire logic rdbi_en,
   output logic [15:0] dq_i,
   output logic [1:0] dmi_i,
   output int viol,
   output logic [7:0] open_o
);
   logic [255:0] mem [8];
   logic [4:0] op;
   logic [4:0] wop;
   logic fl;
   logic w2;
   int now, rd_at, rd_bank, nb, wb;
   int t_act [8];
   int t_pre [8];
   int t_rdy [8];
   int need_rp [8];

   task automatic chk(input logic ok);
      if (ok !== 1'b1) begin
         viol++;
      end
   endtask

   task automatic command();
      int b, t;
      if (cs_out) begin
         op = ca_out[4:0];
         fl = ca_out[5];
         w2 = 1'b1;
      end else if (w2) begin
         w2 = 1'b0;
         b = int'(ca_out[2:0]);
         case (op)
            drpm_pkg::OP_ACT: begin
               chk(!open_o[b] && now - t_pre[b] >= need_rp[b] && now - t_act[b] >= int'(drpm_pkg::N_RC));
               open_o[b] = 1'b1;
               t_act[b] = now;
               t_rdy[b] = now + int'(drpm_pkg::N_RAS);
            end
            drpm_pkg::OP_PRE: begin
               for (int k = 0; k < 8; k++) if (fl || k == b) begin
                  if (open_o[k]) chk(now >= t_rdy[k]);
                  t_pre[k] = now;
                  need_rp[k] = fl ? int'(drpm_pkg::N_RPAB) : int'(drpm_pkg::N_RPPB);
                  open_o[k] = 1'b0;
               end
            end
            default: begin
               chk(open_o[b] && now - t_act[b] >= int'(drpm_pkg::N_RCD) && (op != drpm_pkg::OP_MWR || dm_en));
               if (op == drpm_pkg::OP_RD) begin
                  rd_at = now + drpm_pkg::RL;
                  rd_bank = b;
                  t = now + int'(drpm_pkg::N_RD2PRE);
               end else begin
                  wop = op;
                  wb = b;
                  nb = 0;
                  t = now + int'(drpm_pkg::N_WR2PRE);
               end
               if (t > t_rdy[b]) t_rdy[b] = t;
               // auto precharge waits for row time and recovery
               if (fl) begin
                  open_o[b] = 1'b0;
                  t_pre[b] = t_rdy[b];
                  need_rp[b] = int'(drpm_pkg::N_RPPB);
               end
            end
         endcase
      end
   endtask

   task automatic data_edge();
      int j;
      logic [7:0] d;
      logic msk;
      if (dq_oe && nb < 16) begin
         for (int y = 0; y < 2; y++) begin
            d = dq_o[y*8+:8];
            // plain write holds mask pin low
            if (wop == drpm_pkg::OP_WR && dm_en && !wdbi_en) chk(dmi_oe && !dmi_o[y]);
            msk = wop == drpm_pkg::OP_MWR && dm_en && (wdbi_en ? (!dmi_o[y] && $countones(d[7:2]) >= 5) : dmi_o[y]);
            if (!msk && wdbi_en && dmi_o[y]) d = ~d;
            if (!msk) mem[wb][nb*16+y*8+:8] = d;
         end
         nb++;
      end
      // Beat 0 leaves on the falling edge that follows the latency's rising edge.
      j = 2 * (now - rd_at) - (ck_out ? 1 : 0);
      dmi_i = ~dmi_i;
      if (rd_at >= 0 && j >= 0 && j < 16) begin
         for (int y = 0; y < 2; y++) begin
            d = mem[rd_bank][j*16+y*8+:8];
            msk = rdbi_en && $countones(d) > 4;
            dq_i[y*8+:8] = msk ? ~d : d;
            if (rdbi_en) dmi_i[y] = msk;
         end
      end else begin
         dq_i = ~dq_i;
      end
   endtask

   initial begin
      viol = 0;
      now = 0;
      rd_at = -1;
      nb = 16;
      w2 = 1'b0;
      open_o = 8'h00;
      dq_i = 16'h0000;
      dmi_i = 2'h0;
      for (int b = 0; b < 8; b++) begin
         t_act[b] = -1000;
         t_pre[b] = -1000;
         t_rdy[b] = 0;
         need_rp[b] = 0;
         mem[b] = '0;
      end
      forever begin
         @(ck_out);
         #1;
         if (ck_out) begin
            now++;
            command();
         end
         data_edge();
      end
   end
endmodule
`default_nettype wire

/* File: verification/drpm_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module dram_precharge_and_data_mask_tb_top;
   logic clock, rst_n, dm, wdbi, rdbi, req_valid, req_ready, req_err, rd_valid;
   logic ck_out, cs_out, dq_oe, dmi_oe;
   logic [255:0] rd_data;
   logic [5:0] ca_out;
   logic [15:0] dq_o, dq_i;
   logic [1:0] dmi_o, dmi_i;
   logic [7:0] open_o;
   logic [255:0] d1, d2, d3, ex;
   drpm_pkg::drpm_req_t req;
   int viol, fail_count, n_checks;

   drpm_ctrl dut (.clock(clock), .rst_n(rst_n), .cfg_dm_en(dm), .cfg_wdbi_en(wdbi), .cfg_rdbi_en(rdbi),
      .req_valid(req_valid), .req_ready(req_ready), .req(req), .req_err(req_err), .rd_valid(rd_valid),
      .rd_data(rd_data), .ck_out(ck_out), .cs_out(cs_out), .ca_out(ca_out), .dq_o(dq_o), .dq_oe(dq_oe),
      .dq_i(dq_i), .dmi_o(dmi_o), .dmi_oe(dmi_oe), .dmi_i(dmi_i));
   drpm_dev_model dev (.ck_out(ck_out), .cs_out(cs_out), .ca_out(ca_out), .dq_o(dq_o), .dq_oe(dq_oe),
      .dmi_o(dmi_o), .dmi_oe(dmi_oe), .dm_en(dm), .wdbi_en(wdbi), .rdbi_en(rdbi), .dq_i(dq_i),
      .dmi_i(dmi_i), .viol(viol), .open_o(open_o));

   task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   task automatic send(input drpm_pkg::drpm_cmd_t c, input logic [2:0] b, input logic f, input logic [255:0] wd,
      input logic [31:0] wm, input logic e);
      int n;
      @(negedge clock);
      req_valid = 1'b1;
      req = '{cmd: c, bank: b, flag: f, wdata: wd, wmask: wm};
      n = 0;
      #2;
      while (req_ready !== 1'b1 && n < 2000) begin
         @(negedge clock);
         #2;
         n++;
      end
      @(negedge clock);
      req_valid = 1'b0;
      check("req_taken", 256'h1, 256'(n < 2000));
      check("req_err", 256'(e), 256'(req_err));
   endtask

   task automatic rd(input logic [2:0] b, input logic f, input logic [255:0] exp);
      int n;
      send(drpm_pkg::DRPM_CMD_RD, b, f, '0, '0, 1'b0);
      n = 0;
      while (rd_valid !== 1'b1 && n < 200) begin
         @(negedge clock);
         n++;
      end
      check("rd_valid", 256'h1, 256'(rd_valid));
      check("rd_data", exp, rd_data);
   endtask

   function automatic logic [255:0] merge(input logic [255:0] o, input logic [255:0] w, input logic [31:0] m);
      merge = o;
      for (int i = 0; i < 32; i++) if (!m[i]) merge[i*8+:8] = w[i*8+:8];
   endfunction

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial begin
      repeat (40000) @(posedge clock);
      fail_count++;
      give_verdict();
   end

   initial begin
      rst_n = 1'b0;
      {dm, wdbi, rdbi, req_valid} = 4'h0;
      req = '0;
      fail_count = 0;
      n_checks = 0;
      d1 = {8{32'hff0f_f801}};
      d2 = {8{32'h3c7f_00e0}};
      d3 = {8{32'hfffc_0781}};
      repeat (16) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      for (int m = 0; m < 4; m++) begin
         {wdbi, rdbi} = 2'(m);
         send(drpm_pkg::DRPM_CMD_ACT, 3'h3, 1'b0, '0, '0, 1'b0);
         send(drpm_pkg::DRPM_CMD_WR, 3'h3, 1'b0, d1, '0, 1'b0);
         rd(3'h3, 1'b1, d1);
         $display("test inversion mode %0d done", m);
      end
      {dm, wdbi, rdbi} = 3'b100;
      send(drpm_pkg::DRPM_CMD_ACT, 3'h5, 1'b0, '0, '0, 1'b0);
      send(drpm_pkg::DRPM_CMD_WR, 3'h5, 1'b0, d1, '0, 1'b0);
      send(drpm_pkg::DRPM_CMD_WR, 3'h5, 1'b0, d2, 32'h8421_0f30, 1'b0);
      ex = merge(d1, d2, 32'h8421_0f30);
      rd(3'h5, 1'b0, ex);
      wdbi = 1'b1;
      send(drpm_pkg::DRPM_CMD_WR, 3'h5, 1'b0, d3, 32'h1248_c003, 1'b0);
      ex = merge(ex, d3, 32'h1248_c003);
      rd(3'h5, 1'b0, ex);
      {dm, wdbi} = 2'b00;
      send(drpm_pkg::DRPM_CMD_WR, 3'h5, 1'b0, d2, 32'h0000_0001, 1'b1);
      rd(3'h5, 1'b0, ex);
      $display("test masked write done");
      send(drpm_pkg::DRPM_CMD_ACT, 3'h1, 1'b0, '0, '0, 1'b0);
      send(drpm_pkg::DRPM_CMD_PRE, 3'h2, 1'b1, '0, '0, 1'b0);
      repeat (4) @(negedge clock);
      check("open_after_all", 256'h0, 256'(open_o));
      send(drpm_pkg::DRPM_CMD_ACT, 3'h1, 1'b0, '0, '0, 1'b0);
      send(drpm_pkg::DRPM_CMD_ACT, 3'h6, 1'b0, '0, '0, 1'b0);
      send(drpm_pkg::DRPM_CMD_PRE, 3'h1, 1'b0, '0, '0, 1'b0);
      repeat (4) @(negedge clock);
      check("open_after_one", 256'h40, 256'(open_o));
      send(drpm_pkg::DRPM_CMD_ACT, 3'h1, 1'b0, '0, '0, 1'b0);
      $display("test precharge select done");
      send(drpm_pkg::DRPM_CMD_WR, 3'h6, 1'b0, d3, '0, 1'b0);
      send(drpm_pkg::DRPM_CMD_PRE, 3'h6, 1'b0, '0, '0, 1'b0);
      rd(3'h1, 1'b0, 256'h0);
      send(drpm_pkg::DRPM_CMD_PRE, 3'h1, 1'b0, '0, '0, 1'b0);
      send(drpm_pkg::DRPM_CMD_ACT, 3'h6, 1'b0, '0, '0, 1'b0);
      send(drpm_pkg::DRPM_CMD_WR, 3'h6, 1'b1, d1, '0, 1'b0);
      send(drpm_pkg::DRPM_CMD_ACT, 3'h6, 1'b0, '0, '0, 1'b0);
      rd(3'h6, 1'b1, d1);
      $display("test recovery spacing done");
      check("timing_faults", 256'h0, 256'(viol));
      give_verdict();
   end
endmodule
`default_nettype wire
